// >>> shared/dsc_pkg.sv
// Shared constants and types for the deep standby controller
`default_nettype none
package dsc_pkg;
    // Bus and register map (byte addresses)
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_TRIGGER = 8'h00;
    localparam logic [7:0] OFF_WAKE_FLAGS = 8'h04;
    localparam logic [7:0] OFF_WAKE_CLEAR = 8'h08;
    localparam logic [7:0] OFF_WAKE_EN = 8'h0c;
    localparam logic [7:0] OFF_RESET_CAUSE = 8'h10;
    localparam logic [7:0] OFF_CAUSE_CLEAR = 8'h14;
    localparam logic [7:0] OFF_IO_HOLD = 8'h18;
    localparam logic [7:0] OFF_POWER_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h24;
    localparam logic [7:0] OFF_IRQ_EN = 8'h28;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Field widths and positions
    localparam int unsigned WAKE_N = 8;
    localparam int unsigned TRG_W = 2;
    localparam int unsigned TRG_LIGHT_BIT = 0;
    localparam int unsigned TRG_DEEP_BIT = 1;
    localparam int unsigned CAUSE_W = 1;
    localparam int unsigned CAUSE_DEEP_BIT = 0;
    localparam int unsigned IO_HOLD_W = 2;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_WAKE_BIT = 0;
    localparam int unsigned IRQ_ENTER_BIT = 1;

    // Reset values
    localparam logic [WAKE_N-1:0] WAKE_EN_RESET = 8'h00;
    localparam logic [IO_HOLD_W-1:0] IO_HOLD_RESET = 2'h0;
    localparam logic [IO_HOLD_W-1:0] IO_HOLD_ALL = 2'h3;

    // Timing: restart request width after a deep standby wake
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RESTART_HOLD_NS = 1000;
    localparam int unsigned RESTART_CYCLES = (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 5;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_LIGHT,
        ST_DEEP,
        ST_RESTART
    } dsc_state_t;
endpackage : dsc_pkg
`default_nettype wire

// >>> rtl/dsc_sync.sv
// Two-stage synchroniser for asynchronous wake-up pins
`default_nettype none
module dsc_sync #(
    parameter int unsigned W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // First stage feeds only the second stage
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule : dsc_sync
`default_nettype wire

// >>> rtl/dsc_ctrl.sv
// Deep standby power-mode controller with AXI4-Lite register slave
// Notes on behaviour
// - Deep start bit set starts deep standby
// - Deep wake restarts CPU from reset vector
// - Reset cause records deep standby restart
// - Wake source latched, readable after restart
// - Always-on ports hold state in standby
// - Main RAMs kept light, powered off deep
// - Standby RAM bank retained in both modes
// - Isolated IO buffers freeze on deep entry
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module dsc_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic [dsc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dsc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [dsc_pkg::WAKE_N-1:0] wakeup_pin,
    output logic irq,
    output logic cpu_clock_stop,
    output logic cpu_restart_req,
    output logic iso_power_en,
    output logic main_ram_power_en,
    output logic standby_ram_power_en,
    output logic awo_port_hold,
    output logic [dsc_pkg::IO_HOLD_W-1:0] io_hold_release_bits
);
    import dsc_pkg::*;
    // Bus-side state
    logic aw_hold_reg, aw_hold_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic w_hold_reg, w_hold_next;
    logic [31:0] wdata_reg, wdata_next;
    logic wstrb0_reg, wstrb0_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    // Controller state
    dsc_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [TRG_W-1:0] standby_trigger_reg, standby_trigger_next;
    logic [WAKE_N-1:0] wakeup_factor_flags_reg, wakeup_factor_flags_next;
    logic [WAKE_N-1:0] wake_en_reg, wake_en_next;
    logic [CAUSE_W-1:0] reset_cause_flags_reg, reset_cause_flags_next;
    logic [IO_HOLD_W-1:0] io_hold_reg, io_hold_next;
    logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
    logic [IRQ_W-1:0] irq_en_reg, irq_en_next;
    logic [WAKE_N-1:0] wake_sync;
    logic [WAKE_N-1:0] wake_hit;
    logic wr_en;
    logic in_standby;
    logic enter_evt;
    logic wake_evt;
    // Mapped offsets, shared by read and write decode
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        unique case (a)
            OFF_TRIGGER, OFF_WAKE_FLAGS, OFF_WAKE_CLEAR, OFF_WAKE_EN, OFF_RESET_CAUSE, OFF_CAUSE_CLEAR,
            OFF_IO_HOLD, OFF_POWER_STAT, OFF_IRQ_STAT, OFF_IRQ_CLEAR, OFF_IRQ_EN: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped
    // Write strobe for one register, low byte lane only
    function automatic logic wr_hit(input logic en, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off,
                                    input logic strb);
        wr_hit = en && (a == off) && strb;
    endfunction : wr_hit
    dsc_sync #(
        .W(WAKE_N)
    ) u_wake_sync (
        .clk(clk),
        .reset(reset),
        .async_in(wakeup_pin),
        .sync_out(wake_sync)
    );
    assign wake_hit = wake_sync & wake_en_reg;
    assign in_standby = (state_reg == ST_LIGHT) || (state_reg == ST_DEEP);
    assign wr_en = aw_hold_reg && w_hold_reg && !bvalid_reg;
    // Bus channels: address and data latched in either order, one write at a time
    always_comb begin
        aw_hold_next = aw_hold_reg;
        awaddr_next = awaddr_reg;
        w_hold_next = w_hold_reg;
        wdata_next = wdata_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb0_next = s_axi_wstrb[0];
        end
        if (wr_en) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            // Write-only and unmapped offsets read as zero
            unique case (s_axi_araddr)
                OFF_TRIGGER: rdata_next = 32'(standby_trigger_reg);
                OFF_WAKE_FLAGS: rdata_next = 32'(wakeup_factor_flags_reg);
                OFF_WAKE_EN: rdata_next = 32'(wake_en_reg);
                OFF_RESET_CAUSE: rdata_next = 32'(reset_cause_flags_reg);
                OFF_IO_HOLD: rdata_next = 32'(io_hold_reg);
                OFF_POWER_STAT: rdata_next = 32'(state_reg);
                OFF_IRQ_STAT: rdata_next = 32'(irq_stat_reg);
                OFF_IRQ_EN: rdata_next = 32'(irq_en_reg);
                default: rdata_next = 32'h0000_0000;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            w_hold_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            aw_hold_reg <= aw_hold_next;
            awaddr_reg <= awaddr_next;
            w_hold_reg <= w_hold_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end
    // Mode sequencing and register file; hardware sets win over software clears
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        standby_trigger_next = standby_trigger_reg;
        wakeup_factor_flags_next = wakeup_factor_flags_reg;
        wake_en_next = wake_en_reg;
        reset_cause_flags_next = reset_cause_flags_reg;
        io_hold_next = io_hold_reg;
        irq_stat_next = irq_stat_reg;
        irq_en_next = irq_en_reg;
        enter_evt = 1'b0;
        wake_evt = 1'b0;
        // Software side effects first, hardware events override below
        if (wr_hit(wr_en, awaddr_reg, OFF_TRIGGER, wstrb0_reg)) begin
            standby_trigger_next = wdata_reg[TRG_W-1:0];
        end
        if (wr_hit(wr_en, awaddr_reg, OFF_WAKE_CLEAR, wstrb0_reg)) begin
            wakeup_factor_flags_next = wakeup_factor_flags_reg & ~wdata_reg[WAKE_N-1:0];
        end
        if (wr_hit(wr_en, awaddr_reg, OFF_WAKE_EN, wstrb0_reg)) begin
            wake_en_next = wdata_reg[WAKE_N-1:0];
        end
        if (wr_hit(wr_en, awaddr_reg, OFF_CAUSE_CLEAR, wstrb0_reg)) begin
            reset_cause_flags_next = reset_cause_flags_reg & ~wdata_reg[CAUSE_W-1:0];
        end
        // Writing zero releases a hold group; a one never sets it
        if (wr_hit(wr_en, awaddr_reg, OFF_IO_HOLD, wstrb0_reg)) begin
            io_hold_next = io_hold_reg & wdata_reg[IO_HOLD_W-1:0];
        end
        if (wr_hit(wr_en, awaddr_reg, OFF_IRQ_CLEAR, wstrb0_reg)) begin
            irq_stat_next = irq_stat_reg & ~wdata_reg[IRQ_W-1:0];
        end
        if (wr_hit(wr_en, awaddr_reg, OFF_IRQ_EN, wstrb0_reg)) begin
            irq_en_next = wdata_reg[IRQ_W-1:0];
        end
        unique case (state_reg)
            ST_RUN: begin
                // Deep takes priority if both start bits are set
                if (standby_trigger_reg[TRG_DEEP_BIT]) begin
                    state_next = ST_DEEP;
                    enter_evt = 1'b1;
                    io_hold_next = IO_HOLD_ALL;
                end else if (standby_trigger_reg[TRG_LIGHT_BIT]) begin
                    state_next = ST_LIGHT;
                    enter_evt = 1'b1;
                end
            end
            ST_LIGHT: begin
                // Light wake resumes code in place, no restart
                if (|wake_hit) begin
                    state_next = ST_RUN;
                    wake_evt = 1'b1;
                end
            end
            ST_DEEP: begin
                if (|wake_hit) begin
                    state_next = ST_RESTART;
                    cnt_next = CNT_W'(RESTART_CYCLES - 1);
                    wake_evt = 1'b1;
                    reset_cause_flags_next[CAUSE_DEEP_BIT] = 1'b1;
                end
            end
            ST_RESTART: begin
                if (cnt_reg == '0) begin
                    state_next = ST_RUN;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase
        if (wake_evt) begin
            wakeup_factor_flags_next = wakeup_factor_flags_next | wake_hit;
            standby_trigger_next = '0;
            irq_stat_next[IRQ_WAKE_BIT] = 1'b1;
        end
        if (enter_evt) begin
            irq_stat_next[IRQ_ENTER_BIT] = 1'b1;
        end
    end
    // Flags and hold bits live in the always-on domain, so survive the restart
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_RUN;
            cnt_reg <= '0;
            standby_trigger_reg <= '0;
            wakeup_factor_flags_reg <= '0;
            wake_en_reg <= WAKE_EN_RESET;
            reset_cause_flags_reg <= '0;
            io_hold_reg <= IO_HOLD_RESET;
            irq_stat_reg <= '0;
            irq_en_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            standby_trigger_reg <= standby_trigger_next;
            wakeup_factor_flags_reg <= wakeup_factor_flags_next;
            wake_en_reg <= wake_en_next;
            reset_cause_flags_reg <= reset_cause_flags_next;
            io_hold_reg <= io_hold_next;
            irq_stat_reg <= irq_stat_next;
            irq_en_reg <= irq_en_next;
        end
    end

    // Bus handshakes; no new address while a response waits
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Power controls decoded from the state register; standby RAM power tied on, IO hold bits from io_hold_reg
    assign cpu_clock_stop = in_standby;
    assign cpu_restart_req = (state_reg == ST_RESTART);
    assign iso_power_en = (state_reg != ST_DEEP);
    assign main_ram_power_en = (state_reg != ST_DEEP);
    assign standby_ram_power_en = 1'b1;
    assign awo_port_hold = in_standby;
    assign io_hold_release_bits = io_hold_reg;
    assign irq = |(irq_stat_reg & irq_en_reg);
endmodule : dsc_ctrl
`default_nettype wire

// >>> verification/dsc_ctrl_sva.sv
// Assertion checker for the deep standby controller outputs
`default_nettype none
module dsc_ctrl_sva
    import dsc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cpu_clock_stop,
    input wire logic cpu_restart_req,
    input wire logic iso_power_en,
    input wire logic main_ram_power_en,
    input wire logic standby_ram_power_en,
    input wire logic awo_port_hold,
    input wire logic [dsc_pkg::IO_HOLD_W-1:0] io_hold_release_bits
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] run_cnt_reg;
    logic [7:0] run_cnt_next;

    // Length of the current restart request, too long for a repetition
    always_comb begin
        run_cnt_next = cpu_restart_req ? run_cnt_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk) begin
        run_cnt_reg <= reset ? 8'h00 : run_cnt_next;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    ram_follow_iso_a: assert property (main_ram_power_en == iso_power_en)
        else $error("main ram power differs from isolated area power");
    sram_kept_a: assert property (standby_ram_power_en)
        else $error("standby ram bank lost power");
    awo_hold_a: assert property (awo_port_hold == cpu_clock_stop)
        else $error("always-on port hold differs from standby state");
    deep_freeze_a: assert property ($fell(iso_power_en) |-> io_hold_release_bits == IO_HOLD_ALL)
        else $error("io hold not set on deep entry");
    hold_set_deep_a: assert property ((io_hold_release_bits & ~$past(io_hold_release_bits)) != 2'h0 |-> !iso_power_en)
        else $error("io hold bit set outside deep standby");
    deep_stopped_a: assert property (!iso_power_en |-> cpu_clock_stop)
        else $error("cpu clock running with isolated area off");
    restart_after_deep_a: assert property ($rose(cpu_restart_req) |-> !$past(iso_power_en) && iso_power_en)
        else $error("restart request not preceded by deep standby");
    restart_len_a: assert property ($fell(cpu_restart_req) |-> run_cnt_reg == 8'(RESTART_CYCLES))
        else $error("restart request of wrong length");
    restart_awake_a: assert property (cpu_restart_req |-> !cpu_clock_stop && main_ram_power_en)
        else $error("restart request while still in standby");
    hold_in_restart_a: assert property (cpu_restart_req |-> io_hold_release_bits == IO_HOLD_ALL)
        else $error("io hold released during restart");

    // Main scenarios reached
    deep_entry_c: cover property ($fell(iso_power_en));
    light_entry_c: cover property (cpu_clock_stop && iso_power_en);
    restart_done_c: cover property ($fell(cpu_restart_req));
endmodule : dsc_ctrl_sva

bind dsc_ctrl dsc_ctrl_sva u_dsc_ctrl_sva (.clk, .reset, .cpu_clock_stop, .cpu_restart_req, .iso_power_en,
    .main_ram_power_en, .standby_ram_power_en, .awo_port_hold, .io_hold_release_bits);
`default_nettype wire

// >>> verification/dsc_wake_src.sv
// Wake-up event source model driving the wake pins
`default_nettype none
module dsc_wake_src
    import dsc_pkg::*;
(
    input wire logic clk,
    output logic [dsc_pkg::WAKE_N-1:0] wakeup_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins idle low like a pulled-down line
    initial wakeup_pin = 8'h00;

    // One level pulse, long enough to pass the synchroniser
    task automatic fire(input int unsigned idx, input int unsigned dly);
        repeat (dly) @(posedge clk);
        wakeup_pin[idx] <= 1'b1;
        repeat (6) @(posedge clk);
        wakeup_pin[idx] <= 1'b0;
    endtask : fire
endmodule : dsc_wake_src
`default_nettype wire

// >>> verification/dsc_ctrl_tb.sv
// Self-checking testbench for the deep standby controller
`default_nettype none
module dsc_ctrl_tb;
    import dsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, clk_stop, restart, iso_en, ram_en, sram_en, awo_hold;
    logic [1:0] bresp, rresp, io_hold;
    logic [31:0] rdata;
    logic [WAKE_N-1:0] wake;
    logic [7:0] rst_offs [8] = '{OFF_TRIGGER, OFF_WAKE_FLAGS, OFF_WAKE_EN, OFF_RESET_CAUSE, OFF_IO_HOLD,
        OFF_POWER_STAT, OFF_IRQ_STAT, OFF_IRQ_EN};
    logic [1:0] trigs [3] = '{2'h2, 2'h1, 2'h3};
    int n_errors = 0;
    int n_tests = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    dsc_ctrl u_dsc_ctrl (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wakeup_pin(wake), .irq(irq),
        .cpu_clock_stop(clk_stop), .cpu_restart_req(restart), .iso_power_en(iso_en),
        .main_ram_power_en(ram_en), .standby_ram_power_en(sram_en), .awo_port_hold(awo_hold),
        .io_hold_release_bits(io_hold));
    dsc_wake_src u_dsc_wake_src (.clk(clk), .wakeup_pin(wake));

    function automatic logic [31:0] exp_state(input logic [1:0] trig);
        return trig[1] ? 32'h2 : 32'h1;
    endfunction : exp_state

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Write with both channels offered together, held until each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int t;
        t = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && t < 50);
        bready <= 1'b0;
        chk("bvalid", 32'h1, 32'(bvalid));
        chk("bresp", 32'(er), 32'(bresp));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int t;
        t = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && t < 50);
        rready <= 1'b0;
        chk("rvalid", 32'h1, 32'(rvalid));
        chk("rresp", 32'(er), 32'(rresp));
        chk("rdata", e, rdata);
    endtask : rd

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        int p;
        int t;
        logic [1:0] trig;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        void'($urandom(59760));
        foreach (rst_offs[i]) rd(rst_offs[i], 32'h0, RESP_OKAY);
        rd(8'h2c, 32'h0, RESP_SLVERR);
        wr(8'hfc, 32'hff, RESP_SLVERR);
        wr(OFF_IRQ_EN, 32'h3, RESP_OKAY);
        // Low byte lane off: the write is answered but leaves the register alone
        wstrb <= 4'he;
        wr(OFF_IRQ_EN, 32'h0, RESP_OKAY);
        wstrb <= 4'h1;
        rd(OFF_IRQ_EN, 32'h3, RESP_OKAY);
        // Pins are ignored while running
        wr(OFF_WAKE_EN, 32'hff, RESP_OKAY);
        u_dsc_wake_src.fire($urandom % WAKE_N, 0);
        rd(OFF_WAKE_FLAGS, 32'h0, RESP_OKAY);
        // Each start-bit setting (deep, light, both): enter standby, wake on one enabled pin, check and clear
        foreach (trigs[k]) begin
            trig = trigs[k];
            p = $urandom % WAKE_N;
            wr(OFF_WAKE_EN, 32'(1) << p, RESP_OKAY);
            wr(OFF_TRIGGER, 32'(trig), RESP_OKAY);
            repeat (3) @(posedge clk);
            rd(OFF_POWER_STAT, exp_state(trig), RESP_OKAY);
            chk("clock stop", 32'h1, 32'(clk_stop));
            chk("iso power", 32'(!trig[1]), 32'(iso_en));
            chk("main ram power", 32'(!trig[1]), 32'(ram_en));
            chk("standby ram power", 32'h1, 32'(sram_en));
            chk("port hold", 32'h1, 32'(awo_hold));
            chk("io hold", trig[1] ? 32'h3 : 32'h0, 32'(io_hold));
            chk("irq", 32'h1, 32'(irq));
            // A pin that is not enabled must not wake
            u_dsc_wake_src.fire((p + 1) % WAKE_N, 0);
            chk("still standby", 32'h1, 32'(clk_stop));
            fork
                u_dsc_wake_src.fire(p, $urandom % 4);
            join_none
            t = 0;
            while (clk_stop !== 1'b0 && t < 50) begin
                @(posedge clk);
                t++;
            end
            t = 0;
            while (restart === 1'b1 && t < 100) begin
                @(posedge clk);
                t++;
            end
            chk("restart cycles", trig[1] ? 32'(RESTART_CYCLES) : 32'h0, 32'(t));
            rd(OFF_WAKE_FLAGS, 32'(1) << p, RESP_OKAY);
            rd(OFF_RESET_CAUSE, 32'(trig[1]), RESP_OKAY);
            rd(OFF_TRIGGER, 32'h0, RESP_OKAY);
            rd(OFF_POWER_STAT, 32'h0, RESP_OKAY);
            rd(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
            wr(OFF_IRQ_EN, 32'h0, RESP_OKAY);
            chk("irq masked", 32'h0, 32'(irq));
            wr(OFF_IRQ_EN, 32'h3, RESP_OKAY);
            wr(OFF_IRQ_CLEAR, 32'h3, RESP_OKAY);
            chk("irq cleared", 32'h0, 32'(irq));
            rd(OFF_IO_HOLD, trig[1] ? 32'h3 : 32'h0, RESP_OKAY);
            wr(OFF_IO_HOLD, 32'h0, RESP_OKAY);
            rd(OFF_IO_HOLD, 32'h0, RESP_OKAY);
            wr(OFF_WAKE_CLEAR, 32'hff, RESP_OKAY);
            wr(OFF_CAUSE_CLEAR, 32'h1, RESP_OKAY);
            rd(OFF_WAKE_FLAGS, 32'h0, RESP_OKAY);
            rd(OFF_RESET_CAUSE, 32'h0, RESP_OKAY);
        end
        finish_test();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end
endmodule : dsc_ctrl_tb
`default_nettype wire
